// >>> rtl/mtd_defines.svh
/*
 * Constants of the Morse tone decoder: clock rates, sample and block
 * timing, filter coefficient, gap ratios and character codes.
 * Assumes a 40 MHz system clock; included by bare name.
 */
`ifndef MTD_DEFINES_SVH
`define MTD_DEFINES_SVH

`define MTD_CLK_HZ 40000000
`define MTD_MS_PER_S 1000
`define MTD_SAMPLE_RATE_HZ 12019
`define MTD_SAMPLE_DIV (`MTD_CLK_HZ / `MTD_SAMPLE_RATE_HZ)
`define MTD_BLOCK_LEN 48
`define MTD_BLOCK_MS 4
// Q14 of 2*cos(2*pi*700/12019), the 700 Hz receive tone
`define MTD_GOERTZEL_COEF 30599
`define MTD_MID_SCALE 10'h200
`define MTD_VOL_MAX 7'h63
`define MTD_VOL_STEP 5
// Phase step per Hz is 2^24/40e6, held as a 16-bit fraction
`define MTD_PHASE_MUL 27487
`define MTD_DIT_MS_PER_WPM 1200
`define MTD_DAH_SPLIT 2
`define MTD_CHAR_GAP 2
`define MTD_WORD_GAP 5
`define MTD_CODE_EMPTY 8'h01
`define MTD_CODE_WORD 8'h00
`define MTD_DIT_RST 16'h003c
`define MTD_THR_RST 16'h0100

`endif

// >>> rtl/mtd_pkg.sv
/*
 * Types shared by the Morse tone decoder modules.
 * Assumes nothing of its surroundings.
 */
package mtd_pkg;

    typedef enum logic [1:0] {
        MTD_ST_IDLE = 2'b00,
        MTD_ST_MARK = 2'b01,
        MTD_ST_SPACE = 2'b10
    } mtd_state_t;

    typedef enum logic [1:0] {
        MTD_SRC_RX = 2'b00,
        MTD_SRC_TX = 2'b01,
        MTD_SRC_EDIT = 2'b10
    } mtd_src_t;

endpackage : mtd_pkg

// >>> rtl/mtd_goertzel.sv
/*
 * Single-bin tone filter: one level result per block of samples.
 * Assumes samples are offset-binary and at least two clocks apart.
 */
`timescale 1ns/1ps
`include "mtd_defines.svh"

module mtd_goertzel #(
    parameter int BLOCK_LEN = `MTD_BLOCK_LEN,
    parameter logic signed [15:0] COEF = 16'(`MTD_GOERTZEL_COEF)
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Samples
    input wire logic sampleValid,
    input wire logic [9:0] sample,
    // Result
    output logic levelValid,
    output logic [15:0] level
);
    import mtd_pkg::*;

    logic signed [23:0] s1, s2, next_s1, next_s2;
    logic [5:0] cnt, next_cnt;
    logic finish, next_finish;
    logic next_levelValid;
    logic [15:0] next_level;
    logic signed [23:0] x, fb, fb2;
    logic signed [39:0] prod;
    logic signed [47:0] pw;

    always_comb begin
        x = 24'($signed({1'b0, sample})) - 24'($signed({1'b0, `MTD_MID_SCALE}));
        prod = 40'(COEF) * 40'(s1);
        fb = prod[37:14];
        fb2 = fb;
        pw = 48'(s1) * 48'(s1) + 48'(s2) * 48'(s2) - 48'(fb2) * 48'(s2);
        next_s1 = s1;
        next_s2 = s2;
        next_cnt = cnt;
        next_finish = 1'b0;
        next_levelValid = 1'b0;
        next_level = level;
        if (finish) begin
            // Power of the bin; saturate rather than wrap on strong input
            next_levelValid = 1'b1;
            if (pw < 0) begin
                next_level = 16'h0000;
            end else if (|pw[47:32]) begin
                next_level = 16'hffff;
            end else begin
                next_level = pw[31:16];
            end
            next_s1 = 24'sh000000;
            next_s2 = 24'sh000000;
        end else if (sampleValid) begin
            next_s1 = x + fb - s2;
            next_s2 = s1;
            if (cnt == 6'(BLOCK_LEN - 1)) begin
                next_cnt = 6'h00;
                next_finish = 1'b1;
            end else begin
                next_cnt = cnt + 6'h01;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            s1 <= 24'sh000000;
            s2 <= 24'sh000000;
            cnt <= 6'h00;
            finish <= 1'b0;
            levelValid <= 1'b0;
            level <= 16'h0000;
        end else begin
            s1 <= next_s1;
            s2 <= next_s2;
            cnt <= next_cnt;
            finish <= next_finish;
            levelValid <= next_levelValid;
            level <= next_level;
        end
    end

endmodule : mtd_goertzel

// >>> rtl/mtd_decoder.sv
/*
 * Morse decoder with sidetone: samples the receive converter, detects the
 * tone, blanks noise, times marks and spaces and emits characters; also
 * makes the key-down sidetone. Assumes the converter answers each start
 * pulse with a ready pulse on this clock, and a key pin from outside.
 */
// Summary of operation
// - A square sidetone at the set frequency is mixed into the audio while the key is down.
// - Sidetone level scales with the volume setting, 99 loudest, lower quieter.
// - Received audio is 10-bit converter samples taken 12019 times per second.
// - Each block of 48 samples passes one single-bin tone filter of about 250 Hz width.
// - One level result is produced per block, every 4 ms.
// - A tone is present when the level exceeds the threshold, absent otherwise.
// - Tone pulses shorter than the noise blanker time in ms are ignored.
// - Mark and space lengths against the dit average give dit or dah and gap kind.
// - The dit average is an exponential average weighted by the speed setting.
// - The threshold is an exponential average of levels weighted by one over its setting.
// - Received signals are not decoded while receive decoding is off.
// - Own keying during transmit is decoded to the display only when enabled.
// - Keying while editing is decoded into the editor when enabled.
// - Start of transmit or editing loads the keyer speed into the dit average.
`timescale 1ns/1ps
`include "mtd_defines.svh"

module mtd_decoder #(
    parameter int MS_CYCLES = `MTD_CLK_HZ / `MTD_MS_PER_S,
    parameter int SAMPLE_DIV = `MTD_SAMPLE_DIV
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Audio converter
    output logic adcStart,
    input wire logic adcReady,
    input wire logic [9:0] adcData,
    output logic [9:0] audioOut,
    // Key line, low while the key is down
    input wire logic keyIn_b,
    output logic txKey,
    // Operating state
    input wire logic txActive,
    input wire logic editActive,
    // Settings
    input wire logic [11:0] sidetoneFreq,
    input wire logic [6:0] sidetoneVol,
    input wire logic [5:0] keyerWpm,
    input wire logic [7:0] blankMs,
    input wire logic [4:0] speedAvg,
    input wire logic [4:0] amplAvg,
    input wire logic rxDecodeEn,
    input wire logic txDecodeEn,
    input wire logic editDecodeEn,
    // Detector state
    output logic toneDetect,
    // Display and editor
    output logic charValid,
    output logic [7:0] charCode,
    output logic editCharValid,
    output logic [7:0] editCharCode
);
    import mtd_pkg::*;

    function automatic logic [15:0] emaStep(input logic [15:0] avg, input logic [15:0] meas,
                                            input logic [4:0] w);
        logic signed [17:0] diff;
        logic [4:0] wd;
        wd = (w == 5'h00) ? 5'h01 : w;
        diff = $signed({2'b00, meas}) - $signed({2'b00, avg});
        diff = diff / $signed({13'h0000, wd});
        return 16'($signed({2'b00, avg}) + diff);
    endfunction : emaStep

    // Timebase, converter and sidetone
    logic [11:0] sampleCnt, next_sampleCnt;
    logic [15:0] msCnt, next_msCnt;
    logic msTick, next_msTick, next_adcStart;
    logic [9:0] rxSample, next_rxSample, next_audioOut;
    logic [23:0] phase, next_phase;
    logic k1, k2, k3, keyState, next_keyState, next_txKey;
    logic keyDown;
    logic [6:0] volC;
    logic [10:0] amp;
    logic signed [12:0] mix;

    assign keyDown = ~keyState;

    always_comb begin
        next_sampleCnt = (sampleCnt == 12'(SAMPLE_DIV - 1)) ? 12'h000 : sampleCnt + 12'h001;
        next_adcStart = (sampleCnt == 12'(SAMPLE_DIV - 1));
        next_msTick = (msCnt == 16'(MS_CYCLES - 1));
        next_msCnt = next_msTick ? 16'h0000 : msCnt + 16'h0001;
        next_rxSample = adcReady ? adcData : rxSample;
        // Key pin counts as changed once the last two stages agree
        next_keyState = (k2 == k3) ? k3 : keyState;
        next_txKey = ~next_keyState;
        next_phase = phase + 24'((32'(sidetoneFreq) * 32'(`MTD_PHASE_MUL)) >> 16);
        volC = (sidetoneVol > `MTD_VOL_MAX) ? `MTD_VOL_MAX : sidetoneVol;
        amp = 11'(volC * `MTD_VOL_STEP);
        mix = 13'($signed({3'b000, rxSample}));
        if (keyDown) begin
            mix = phase[23] ? mix + 13'($signed({2'b00, amp}))
                            : mix - 13'($signed({2'b00, amp}));
        end
        if (mix < 0) begin
            next_audioOut = 10'h000;
        end else if (mix > 13'sh03ff) begin
            next_audioOut = 10'h3ff;
        end else begin
            next_audioOut = mix[9:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            sampleCnt <= 12'h000;
            msCnt <= 16'h0000;
            msTick <= 1'b0;
            adcStart <= 1'b0;
            rxSample <= `MTD_MID_SCALE;
            audioOut <= `MTD_MID_SCALE;
            phase <= 24'h000000;
            k1 <= 1'b1;
            k2 <= 1'b1;
            k3 <= 1'b1;
            keyState <= 1'b1;
            txKey <= 1'b0;
        end else begin
            sampleCnt <= next_sampleCnt;
            msCnt <= next_msCnt;
            msTick <= next_msTick;
            adcStart <= next_adcStart;
            rxSample <= next_rxSample;
            audioOut <= next_audioOut;
            phase <= next_phase;
            k1 <= keyIn_b;
            k2 <= k1;
            k3 <= k2;
            keyState <= next_keyState;
            // Keying path never sees the sidetone
            txKey <= next_txKey;
        end
    end

    // Tone detector
    logic levelValid;
    logic [15:0] level, thr, next_thr;
    logic [7:0] onMs, next_onMs;
    logic next_toneDetect, rawTone;

    mtd_goertzel #(
        .BLOCK_LEN(`MTD_BLOCK_LEN),
        .COEF(16'(`MTD_GOERTZEL_COEF))
    ) u_filter (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .sampleValid(adcReady),
        .sample(adcData),
        .levelValid(levelValid),
        .level(level)
    );

    always_comb begin
        next_thr = thr;
        next_onMs = onMs;
        next_toneDetect = toneDetect;
        rawTone = (level > thr);
        if (levelValid) begin
            next_thr = emaStep(thr, level, amplAvg);
            if (rawTone) begin
                next_onMs = (onMs > 8'(255 - `MTD_BLOCK_MS)) ? 8'hff : onMs + 8'(`MTD_BLOCK_MS);
                // Tone only counts once it has lasted at least the blanker time
                next_toneDetect = (next_onMs >= blankMs);
            end else begin
                next_onMs = 8'h00;
                next_toneDetect = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            thr <= `MTD_THR_RST;
            onMs <= 8'h00;
            toneDetect <= 1'b0;
        end else begin
            thr <= next_thr;
            onMs <= next_onMs;
            toneDetect <= next_toneDetect;
        end
    end

    // Symbol timing and character assembly
    mtd_state_t state, next_state;
    mtd_src_t src, next_src, srcNow;
    logic [11:0] dur, next_dur;
    logic [15:0] dit, next_dit, meas;
    logic [7:0] code, next_code, outCode;
    logic busy, next_busy, decOn, mark, emit;
    logic next_charValid, next_editCharValid;
    logic [7:0] next_charCode, next_editCharCode;
    logic [17:0] durN;

    always_comb begin
        next_busy = txActive | editActive;
        if (editActive) begin
            srcNow = MTD_SRC_EDIT;
            decOn = editDecodeEn;
        end else if (txActive) begin
            srcNow = MTD_SRC_TX;
            decOn = txDecodeEn;
        end else begin
            srcNow = MTD_SRC_RX;
            decOn = rxDecodeEn;
        end
        mark = (srcNow == MTD_SRC_RX) ? toneDetect : keyDown;
        next_src = srcNow;
        next_state = state;
        next_dur = dur;
        next_dit = dit;
        next_code = code;
        meas = 16'h0000;
        emit = 1'b0;
        outCode = code;
        durN = 18'(dur) + 18'h00001;
        if (next_busy && !busy) begin
            next_dit = 16'(`MTD_DIT_MS_PER_WPM / ((keyerWpm == 6'h00) ? 6'h01 : keyerWpm));
        end
        if (!decOn || srcNow != src) begin
            // Half-built character from another source is dropped
            next_state = MTD_ST_IDLE;
            next_code = `MTD_CODE_EMPTY;
            next_dur = 12'h000;
        end else if (msTick) begin
            unique case (state)
                MTD_ST_IDLE: begin
                    if (mark) begin
                        next_state = MTD_ST_MARK;
                        next_dur = 12'h001;
                    end
                end
                MTD_ST_MARK: begin
                    if (mark) begin
                        next_dur = (dur == 12'hfff) ? dur : dur + 12'h001;
                    end else begin
                        if (18'(dur) < 18'(dit) * 18'(`MTD_DAH_SPLIT)) begin
                            meas = 16'(dur);
                            next_code = code[7] ? code : {code[6:0], 1'b0};
                        end else begin
                            meas = 16'(dur / 12'd3);
                            next_code = code[7] ? code : {code[6:0], 1'b1};
                        end
                        next_dit = emaStep(dit, meas, speedAvg);
                        if (next_dit == 16'h0000) begin
                            next_dit = 16'h0001;
                        end
                        next_state = MTD_ST_SPACE;
                        next_dur = 12'h001;
                    end
                end
                MTD_ST_SPACE: begin
                    if (mark) begin
                        next_state = MTD_ST_MARK;
                        next_dur = 12'h001;
                    end else begin
                        next_dur = (dur == 12'hfff) ? dur : dur + 12'h001;
                        if (code != `MTD_CODE_EMPTY) begin
                            if (durN >= 18'(dit) * 18'(`MTD_CHAR_GAP)) begin
                                emit = 1'b1;
                                next_code = `MTD_CODE_EMPTY;
                            end
                        end else if (durN >= 18'(dit) * 18'(`MTD_WORD_GAP)) begin
                            emit = 1'b1;
                            outCode = `MTD_CODE_WORD;
                            next_state = MTD_ST_IDLE;
                        end
                    end
                end
                default: begin
                    next_state = MTD_ST_IDLE;
                end
            endcase
        end
        next_charValid = emit && (src != MTD_SRC_EDIT);
        next_editCharValid = emit && (src == MTD_SRC_EDIT);
        next_charCode = next_charValid ? outCode : charCode;
        next_editCharCode = next_editCharValid ? outCode : editCharCode;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state <= MTD_ST_IDLE;
            src <= MTD_SRC_RX;
            dur <= 12'h000;
            dit <= `MTD_DIT_RST;
            code <= `MTD_CODE_EMPTY;
            busy <= 1'b0;
            charValid <= 1'b0;
            charCode <= 8'h00;
            editCharValid <= 1'b0;
            editCharCode <= 8'h00;
        end else begin
            state <= next_state;
            src <= next_src;
            dur <= next_dur;
            dit <= next_dit;
            code <= next_code;
            busy <= next_busy;
            charValid <= next_charValid;
            charCode <= next_charCode;
            editCharValid <= next_editCharValid;
            editCharCode <= next_editCharCode;
        end
    end

endmodule : mtd_decoder

// >>> tb/mtd_adc_model.sv
/*
 * Behavioural audio converter: answers each start pulse with one sample
 * after a bench-chosen delay, either mid-scale or a 700 Hz sine.
 * Assumes the decoder's sys_clk and one start per conversion.
 */
`timescale 1ns/1ps

module mtd_adc_model (
    // Clock
    input wire logic sys_clk,
    // Converter handshake
    input wire logic adcStart,
    output logic adcReady,
    output logic [9:0] adcData,
    // Bench control
    input wire logic toneOn,
    input wire logic [7:0] slowBy
);
    localparam real STEP = 6.2831853 * 700.0 / 12019.0;
    int n = 0;
    int waitCnt = -1;

    initial begin
        adcReady = 1'b0;
        adcData = 10'h155;
    end

    // Data means nothing without adcReady, so it flips every cycle except the one that loads a sample
    always @(posedge sys_clk) begin
        adcReady <= !adcStart && waitCnt == 0;
        if (adcStart) begin
            waitCnt <= slowBy;
            adcData <= ~adcData;
        end else if (waitCnt > 0) begin
            waitCnt <= waitCnt - 1;
            adcData <= ~adcData;
        end else if (waitCnt == 0) begin
            adcData <= toneOn ? 10'(512 + $rtoi(400.0 * $sin(STEP * n))) : 10'h200;
            n <= n + 1;
            waitCnt <= -1;
        end else begin
            adcData <= ~adcData;
        end
    end
endmodule : mtd_adc_model

// >>> tb/mtd_decoder_monitor.sv
/*
 * Port checker of the Morse decoder: converter pacing, key sync and
 * sidetone mixing, decode routing and character pulses.
 * Assumes one clock domain; bound into every decoder instance.
 */
`timescale 1ns/1ps

module mtd_decoder_monitor #(
    parameter int SAMPLE_DIV = 3328
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Converter and audio
    input wire logic adcStart,
    input wire logic adcReady,
    input wire logic [9:0] adcData,
    input wire logic [9:0] audioOut,
    // Key and state
    input wire logic keyIn_b,
    input wire logic txKey,
    input wire logic txActive,
    input wire logic editActive,
    // Settings
    input wire logic [6:0] sidetoneVol,
    input wire logic rxDecodeEn,
    input wire logic txDecodeEn,
    // Display
    input wire logic charValid
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    int gap;
    logic seen;
    logic [9:0] held;
    logic [10:0] amp;
    logic [10:0] hi;
    logic [10:0] lo;

    assign amp = 11'(sidetoneVol > 7'h63 ? 7'h63 : sidetoneVol) * 11'h005;
    assign hi = 11'(held) + amp;
    assign lo = 11'(held) - amp;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            gap <= 0;
            seen <= 1'b0;
            held <= 10'h200;
        end else begin
            gap <= adcStart ? 0 : gap + 1;
            seen <= seen | adcStart;
            if (adcReady) begin
                held <= adcData;
            end
        end
    end

    sequence s_keyDown; !keyIn_b [*6]; endsequence
    sequence s_keyUp; keyIn_b [*6]; endsequence
    sequence s_rxOff; (!rxDecodeEn && !txActive && !editActive) [*2]; endsequence
    sequence s_txOff; (txActive && !editActive && !txDecodeEn) [*2]; endsequence

    property p_start_pulse; adcStart |=> !adcStart; endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
    property p_start_gap; seen |-> (adcStart == (gap == SAMPLE_DIV - 1)); endproperty
    a_start_gap: assert property (p_start_gap) else $error("sample period wrong");
    property p_key_down; s_keyDown |-> txKey; endproperty
    a_key_down: assert property (p_key_down) else $error("key down not seen");
    property p_key_up; s_keyUp |-> !txKey; endproperty
    a_key_up: assert property (p_key_up) else $error("key up not seen");
    // Audio is registered, so it carries the sample and volume of the previous clock
    property p_tone_mix;
        txKey [*3] |-> audioOut == ($past(hi[10]) ? 10'h3ff : $past(hi[9:0]))
            || audioOut == ($past(lo[10]) ? 10'h000 : $past(lo[9:0]));
    endproperty
    a_tone_mix: assert property (p_tone_mix) else $error("sidetone level wrong");
    property p_no_tone; !txKey [*3] |-> audioOut == $past(held); endproperty
    a_no_tone: assert property (p_no_tone) else $error("sidetone with key up");
    property p_rx_off; s_rxOff |-> !charValid; endproperty
    a_rx_off: assert property (p_rx_off) else $error("rx char while off");
    property p_tx_off; s_txOff |-> !charValid; endproperty
    a_tx_off: assert property (p_tx_off) else $error("tx char while off");
    property p_edit_route; editActive [*2] |-> !charValid; endproperty
    a_edit_route: assert property (p_edit_route) else $error("edit char on display");
    property p_char_pulse; charValid |=> !charValid; endproperty
    a_char_pulse: assert property (p_char_pulse) else $error("char pulse too long");
endmodule : mtd_decoder_monitor

bind mtd_decoder mtd_decoder_monitor #(.SAMPLE_DIV(SAMPLE_DIV)) u_mon (
    .sys_clk(sys_clk), .rst_b(rst_b), .adcStart(adcStart), .adcReady(adcReady),
    .adcData(adcData), .audioOut(audioOut), .keyIn_b(keyIn_b), .txKey(txKey),
    .txActive(txActive), .editActive(editActive), .sidetoneVol(sidetoneVol),
    .rxDecodeEn(rxDecodeEn), .txDecodeEn(txDecodeEn), .charValid(charValid)
);

// >>> tb/tb_top.sv
/*
 * Self-checking bench of the Morse decoder: receive bursts, then keyed
 * characters in transmit, edit and muted modes at random speeds.
 * Assumes shortened ms tick and sample period parameters.
 */
`timescale 1ns/1ps

module tb_top;
    localparam int MS = 10;
    localparam int SD = 40;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic keyIn_b = 1'b1, txActive = 1'b0, editActive = 1'b0, toneOn = 1'b0;
    logic rxDecodeEn = 1'b1, txDecodeEn = 1'b1, editDecodeEn = 1'b1;
    logic [11:0] sidetoneFreq = 12'd700;
    logic [6:0] sidetoneVol = 7'd99;
    logic [5:0] keyerWpm = 6'd20;
    logic [7:0] blankMs = 8'd12, slowBy = 8'd0;
    logic [4:0] speedAvg = 5'd4, amplAvg = 5'd16;
    logic adcStart, adcReady, txKey, toneDetect, charValid, editCharValid;
    logic [9:0] adcData, audioOut;
    logic [7:0] charCode, editCharCode;
    int failures = 0, check_count = 0, seed = 32'h1032, ditMs, ampSt;
    bit toneSeen;
    logic [7:0] charQ[$], editQ[$], got[$];

    mtd_decoder #(.MS_CYCLES(MS), .SAMPLE_DIV(SD)) dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .adcStart(adcStart), .adcReady(adcReady),
        .adcData(adcData), .audioOut(audioOut), .keyIn_b(keyIn_b), .txKey(txKey),
        .txActive(txActive), .editActive(editActive), .sidetoneFreq(sidetoneFreq),
        .sidetoneVol(sidetoneVol), .keyerWpm(keyerWpm), .blankMs(blankMs),
        .speedAvg(speedAvg), .amplAvg(amplAvg), .rxDecodeEn(rxDecodeEn),
        .txDecodeEn(txDecodeEn), .editDecodeEn(editDecodeEn), .toneDetect(toneDetect),
        .charValid(charValid), .charCode(charCode), .editCharValid(editCharValid),
        .editCharCode(editCharCode)
    );
    mtd_adc_model adc (
        .sys_clk(sys_clk), .adcStart(adcStart), .adcReady(adcReady),
        .adcData(adcData), .toneOn(toneOn), .slowBy(slowBy)
    );

    initial forever #12.5 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        if (charValid === 1'b1) charQ.push_back(charCode);
        if (editCharValid === 1'b1) editQ.push_back(editCharCode);
        if (toneDetect === 1'b1) toneSeen = 1'b1;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_sim

    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    function automatic logic [7:0] code_of(int pat, int len);
        return 8'((1 << len) | pat);
    endfunction : code_of

    task automatic ms(int n);
        repeat (n * MS) @(negedge sys_clk);
    endtask : ms

    // Tone length in half blocks; a block is 48 samples
    task automatic burst(int halves);
        toneSeen = 1'b0;
        slowBy = 8'($unsigned($random(seed)) % 30);
        toneOn = 1'b1;
        repeat (halves * 24 * SD) @(negedge sys_clk);
        toneOn = 1'b0;
        repeat (96 * SD + 100) @(negedge sys_clk);
        check("toneGone", 16'(toneDetect), 16'h0000);
    endtask : burst

    task automatic sym(bit dah);
        keyIn_b = 1'b0;
        ms(dah ? 3 * ditMs : ditMs);
        check("txKey", 16'(txKey), 16'h0001);
        check("sidetone", 16'(audioOut == 10'(512 + ampSt) || audioOut == 10'(512 - ampSt)), 16'h0001);
        keyIn_b = 1'b1;
        ms(ditMs);
    endtask : sym

    initial begin
        // Bursts and six keyed characters need about 92000 clocks at worst
        repeat (98000) @(posedge sys_clk);
        failures++;
        end_sim();
    end

    initial begin
        repeat (16) @(negedge sys_clk);
        rst_b = 1'b1;
        burst(16);
        check("toneLong", 16'(toneSeen), 16'h0001);
        burst(3);
        check("toneShort", 16'(toneSeen), 16'h0000);
        charQ.delete();
        rxDecodeEn = 1'b0;
        burst(12);
        check("rxOffChars", 16'(charQ.size()), 16'h0000);
        for (int i = 0; i < 6; i++) begin
            int len, pat, mode;
            mode = i % 3;
            len = 1 + $unsigned($random(seed)) % 4;
            pat = $random(seed) & ((1 << len) - 1);
            keyerWpm = 6'(30 + $unsigned($random(seed)) % 11);
            sidetoneVol = i == 0 ? 7'h7f : i == 1 ? 7'h00 : 7'($random(seed));
            sidetoneFreq = 12'(300 + $unsigned($random(seed)) % 700);
            speedAvg = 5'(2 + $unsigned($random(seed)) % 15);
            txDecodeEn = mode != 2;
            ampSt = (sidetoneVol > 99 ? 99 : sidetoneVol) * 5;
            ditMs = 1200 / keyerWpm;
            editActive = mode == 1;
            txActive = mode != 1;
            ms(2);
            for (int s = len - 1; s >= 0; s--) sym(pat[s]);
            ms(5 * ditMs);
            check("charCount", 16'(charQ.size()), mode == 0 ? 16'd2 : 16'd0);
            check("editCount", 16'(editQ.size()), mode == 1 ? 16'd2 : 16'd0);
            if (mode == 1) begin
                got = editQ;
            end else begin
                got = charQ;
            end
            if (got.size() == 2) begin
                check("code", 16'(got[0]), 16'(code_of(pat, len)));
                check("wordGap", 16'(got[1]), 16'h0000);
            end
            txActive = 1'b0;
            editActive = 1'b0;
            charQ.delete();
            editQ.delete();
            ms(2);
        end
        end_sim();
    end
endmodule : tb_top
